// ---- rtl/modbus_bridge_pkg.sv ----
// Constants, register map and state encodings of the Modbus-RTU bridge.
// Assumes a single 25 MHz system clock shared by all users of the package.
`default_nettype none

package modbus_bridge_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_HZ = 25_000_000;
	localparam int BAUD_DEF = 9600;
	localparam int BAUD_DIV_DEF = CLK_HZ / BAUD_DEF;
	localparam int RESP_MS_DEF = 500;
	localparam int RESP_CYC_DEF = (CLK_HZ / 1000) * RESP_MS_DEF;
	localparam int CHAR_BITS = 11;
	localparam int GAP_HALF_BITS = 77;
	localparam int BYTE_BITS = 8;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_BAUD = 8'h04;
	localparam logic [7:0] OFS_RESP = 8'h08;
	localparam logic [7:0] OFS_FBLEN = 8'h0c;
	localparam logic [7:0] OFS_STAT = 8'h10;

	localparam int CB_EN = 0;
	localparam int CB_SLAVE = 1;
	localparam int CB_MODE = 2;
	localparam int CB_TRIG = 4;
	localparam int CB_LEN = 5;
	localparam int CB_PAR = 6;
	localparam logic [7:0] CTRL_RST = 8'h00;

	localparam int SB_TMO = 0;
	localparam int SB_OVF = 1;
	localparam int SB_CRC = 2;
	localparam int SB_BUSY = 3;
	localparam int SB_ID = 8;

	localparam logic [1:0] DISP_CYCLIC = 2'h0;
	localparam logic [1:0] DISP_CHANGE = 2'h1;
	localparam logic [1:0] DISP_REQUEST = 2'h2;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;

	// ****************************************
	// Modbus framing
	// ****************************************
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [7:0] FN_RD_MAX = 8'h04;
	localparam logic [7:0] FN_WR_COILS = 8'h0f;
	localparam logic [7:0] FN_WR_REGS = 8'h10;
	localparam logic [7:0] REQ_FIXED_LEN = 8'h06;
	localparam logic [7:0] REQ_MULTI_HDR = 8'h07;
	localparam logic [7:0] RSP_RD_HDR = 8'h03;
	localparam logic [7:0] RSP_EXC_LEN = 8'h03;
	localparam logic [7:0] RSP_WR_LEN = 8'h06;
	localparam logic [7:0] REQ_BC_POS = 8'h06;
	localparam logic [7:0] CRC_BYTES = 8'h02;
	localparam logic [7:0] MIN_FRAME = 8'h04;

	typedef enum logic [2:0] {ST_IDLE, ST_TX, ST_WAIT, ST_RX, ST_FB_WAIT} fsm_e;
endpackage

`default_nettype wire

// ---- rtl/modbus_rtu_fieldbus_bridge.sv ----
// Modbus-RTU serial bridge between a fixed-length fieldbus image and a UART line.
// Assumes an APB master on the same clock, fieldbus ports on the same clock,
// and rxd and the station switch arriving asynchronously from pins.
`default_nettype none

// What this block does
// - Only binary RTU framing is handled; ASCII frames are never recognised.
// - As serial master, every request starts from fieldbus data.
// - Without length byte, request length follows from the function code.
// - Master appends the CRC to the request before sending.
// - Master hands the slave reply to the fieldbus without CRC.
// - Master flags timeout when no reply starts within response time.
// - Master flags overflow when a reply exceeds the fieldbus length.
// - Cyclic mode sends the next request right after each reply.
// - Change mode sends only on a fieldbus transfer request.
// - Request mode sends only when the first fieldbus byte changes.
// - Trigger byte toward fieldbus counts received records.
// - Length byte sets bytes sent and reports bytes received, CRC excluded.
// - Slave accepts an inquiry only when its address matches the switch.
// - Slave forwards inquiry without address and CRC, with trigger and length.
// - Slave adds own address and CRC to the answer and sends it.
// - Slave flags timeout when the fieldbus answer is late.
// - Slave flags overflow when a telegram exceeds the fieldbus length.
// - Indicator shows the station address of the last frame sent.
// - Baud rate and parity set by software; framing bits fixed.
module modbus_rtu_fieldbus_bridge #(
	parameter int BUF_BYTES = 32,
	parameter int RESP_DEF = modbus_bridge_pkg::RESP_CYC_DEF
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd,
	input wire logic [7:0] station_sw,
	input wire logic fb_wr_en,
	input wire logic [7:0] fb_addr,
	input wire logic [7:0] fb_wr_data,
	input wire logic fb_req,
	output logic [7:0] fb_rd_data,
	output logic fb_update,
	output logic [7:0] led_id,
	output logic timeout_err,
	output logic rx_overflow
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [BUF_BYTES-1:0][7:0] obuf;
		logic [BUF_BYTES-1:0][7:0] ibuf;
		modbus_bridge_pkg::fsm_e st;
		logic [7:0] ctrl;
		logic [15:0] div;
		logic [31:0] resp;
		logic [7:0] fblen;
		logic tmo;
		logic ovf;
		logic crcerr;
		logic [7:0] last_trig;
		logic [7:0] id_s1;
		logic [7:0] id_s2;
		logic [7:0] led;
		logic rx_s1;
		logic rx_s2;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [7:0] fb_rd;
		logic fb_upd;
		logic req_seen;
		logic [15:0] crc;
		logic [7:0] cnt;
		logic [7:0] n;
		logic [7:0] j;
		logic [7:0] p0;
		logic [7:0] p1;
		logic accept;
		logic [31:0] tmr;
		logic [23:0] gap;
		logic gap_arm;
		logic tx_busy;
		logic [10:0] tx_sh;
		logic [3:0] tx_bits;
		logic [15:0] tx_tmr;
		logic txd;
		logic rx_busy;
		logic [10:0] rx_sh;
		logic [3:0] rx_bits;
		logic [15:0] rx_tmr;
	} state_s;

	localparam state_s ST_RST = '{
		st: modbus_bridge_pkg::ST_IDLE,
		ctrl: modbus_bridge_pkg::CTRL_RST,
		div: 16'(modbus_bridge_pkg::BAUD_DIV_DEF),
		resp: 32'(RESP_DEF),
		fblen: 8'(BUF_BYTES),
		txd: 1'b1,
		rx_s1: 1'b1,
		rx_s2: 1'b1,
		default: '0
	};

	state_s q;
	state_s d;
	logic rx_v;
	logic [7:0] rx_b;
	logic frame_end;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < modbus_bridge_pkg::BYTE_BITS; i++) begin
			r = r[0] ? ((r >> 1) ^ modbus_bridge_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// Frame length from address through last data byte
	function automatic logic [7:0] frame_len(input logic [7:0] fn, input logic [7:0] bc,
			input logic resp);
		logic [7:0] r;
		r = modbus_bridge_pkg::REQ_FIXED_LEN;
		if (resp) begin
			if (fn[7]) begin
				r = modbus_bridge_pkg::RSP_EXC_LEN;
			end else if (fn <= modbus_bridge_pkg::FN_RD_MAX) begin
				r = 8'(modbus_bridge_pkg::RSP_RD_HDR + bc);
			end else begin
				r = modbus_bridge_pkg::RSP_WR_LEN;
			end
		end else if (fn == modbus_bridge_pkg::FN_WR_COILS || fn == modbus_bridge_pkg::FN_WR_REGS) begin
			r = 8'(modbus_bridge_pkg::REQ_MULTI_HDR + bc);
		end
		return r;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic en;
		logic slave;
		logic trig_en;
		logic len_en;
		logic [1:0] mode;
		logic [1:0] par;
		logic [7:0] hdr;
		logic [7:0] lenpos;
		logic [7:0] n_lim;
		logic [7:0] k;
		logic [7:0] pos;
		logic [7:0] tx_byte;
		logic [10:0] sh_n;
		logic [23:0] gap_lim;
		logic go;
		logic start_rx;
		logic acc;
		en = 1'b0;
		slave = 1'b0;
		trig_en = 1'b0;
		len_en = 1'b0;
		mode = '0;
		par = '0;
		hdr = '0;
		lenpos = '0;
		n_lim = '0;
		k = '0;
		pos = '0;
		tx_byte = '0;
		sh_n = '0;
		gap_lim = '0;
		go = 1'b0;
		start_rx = 1'b0;
		acc = 1'b0;
		rx_v = 1'b0;
		rx_b = '0;
		frame_end = 1'b0;
		d = q;
		en = q.ctrl[modbus_bridge_pkg::CB_EN];
		slave = q.ctrl[modbus_bridge_pkg::CB_SLAVE];
		trig_en = q.ctrl[modbus_bridge_pkg::CB_TRIG];
		len_en = q.ctrl[modbus_bridge_pkg::CB_LEN];
		mode = q.ctrl[modbus_bridge_pkg::CB_MODE +: 2];
		par = q.ctrl[modbus_bridge_pkg::CB_PAR +: 2];
		hdr = 8'({7'h00, trig_en} + {7'h00, len_en});
		lenpos = {7'h00, trig_en};
		d.rx_s1 = rxd;
		d.rx_s2 = q.rx_s1;
		d.id_s1 = station_sw;
		d.id_s2 = q.id_s1;
		d.fb_upd = 1'b0;

		// ****************************************
		// APB slave, one wait state
		// ****************************************
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		// Writes land at the edge where the master sees pready high
		if (psel && penable && pwrite && q.pready) begin
			unique case (paddr)
				modbus_bridge_pkg::OFS_CTRL: d.ctrl = pwdata[7:0];
				modbus_bridge_pkg::OFS_BAUD: d.div = pwdata[15:0];
				modbus_bridge_pkg::OFS_RESP: d.resp = pwdata;
				modbus_bridge_pkg::OFS_FBLEN: begin
					d.fblen = (pwdata > 32'(BUF_BYTES)) ? 8'(BUF_BYTES) : pwdata[7:0];
				end
				modbus_bridge_pkg::OFS_STAT: begin
					d.tmo = q.tmo & ~pwdata[modbus_bridge_pkg::SB_TMO];
					d.ovf = q.ovf & ~pwdata[modbus_bridge_pkg::SB_OVF];
					d.crcerr = q.crcerr & ~pwdata[modbus_bridge_pkg::SB_CRC];
				end
				default: ;
			endcase
		end
		if (psel && penable && !q.pready) begin
			d.pready = 1'b1;
			d.prdata = '0;
			unique case (paddr)
				modbus_bridge_pkg::OFS_CTRL: d.prdata = {24'h00_0000, q.ctrl};
				modbus_bridge_pkg::OFS_BAUD: d.prdata = {16'h0000, q.div};
				modbus_bridge_pkg::OFS_RESP: d.prdata = q.resp;
				modbus_bridge_pkg::OFS_FBLEN: d.prdata = {24'h00_0000, q.fblen};
				modbus_bridge_pkg::OFS_STAT: begin
					d.prdata[modbus_bridge_pkg::SB_TMO] = q.tmo;
					d.prdata[modbus_bridge_pkg::SB_OVF] = q.ovf;
					d.prdata[modbus_bridge_pkg::SB_CRC] = q.crcerr;
					d.prdata[modbus_bridge_pkg::SB_BUSY] = (q.st != modbus_bridge_pkg::ST_IDLE);
					d.prdata[modbus_bridge_pkg::SB_ID +: 8] = q.led;
				end
				default: d.pslverr = 1'b1;
			endcase
		end

		// ****************************************
		// Fieldbus image ports
		// ****************************************
		if (fb_wr_en && fb_addr < 8'(BUF_BYTES)) d.obuf[fb_addr] = fb_wr_data;
		d.fb_rd = (fb_addr < 8'(BUF_BYTES)) ? q.ibuf[fb_addr] : '0;
		if (fb_req) d.req_seen = 1'b1;

		// ****************************************
		// UART transmit, 11 bit times per character
		// ****************************************
		if (q.tx_busy) begin
			if (q.tx_tmr == '0) begin
				sh_n = {1'b1, q.tx_sh[10:1]};
				d.tx_sh = sh_n;
				d.txd = (q.tx_bits == '0) ? 1'b1 : sh_n[0];
				d.tx_busy = (q.tx_bits != '0);
				d.tx_bits = q.tx_bits - 4'h1;
				d.tx_tmr = q.div - 16'h0001;
			end else begin
				d.tx_tmr = q.tx_tmr - 16'h0001;
			end
		end

		// ****************************************
		// UART receive, mid-bit sampling; parity not checked
		// ****************************************
		if (!q.rx_busy) begin
			if (!q.rx_s2) begin
				d.rx_busy = 1'b1;
				d.rx_tmr = q.div >> 1;
				d.rx_bits = '0;
			end
		end else if (q.rx_tmr == '0) begin
			sh_n = {q.rx_s2, q.rx_sh[10:1]};
			d.rx_sh = sh_n;
			d.rx_tmr = q.div - 16'h0001;
			d.rx_bits = q.rx_bits + 4'h1;
			if (q.rx_bits == '0 && q.rx_s2) begin
				d.rx_busy = 1'b0;
			end else if (q.rx_bits == ((par == modbus_bridge_pkg::PAR_NONE) ?
					4'(modbus_bridge_pkg::CHAR_BITS - 2) : 4'(modbus_bridge_pkg::CHAR_BITS - 1))) begin
				d.rx_busy = 1'b0;
				rx_v = 1'b1;
				rx_b = (par == modbus_bridge_pkg::PAR_NONE) ? sh_n[9:2] : sh_n[8:1];
			end
		end else begin
			d.rx_tmr = q.rx_tmr - 16'h0001;
		end

		// Idle gap ends a frame; no character value delimits it
		gap_lim = 24'(({8'h00, q.div} * 24'(modbus_bridge_pkg::GAP_HALF_BITS)) >> 1);
		if (rx_v || q.rx_busy) begin
			d.gap = '0;
			d.gap_arm = q.gap_arm | rx_v;
		end else if (q.gap_arm) begin
			d.gap = q.gap + 24'h00_0001;
			if (q.gap >= gap_lim) begin
				frame_end = 1'b1;
				d.gap_arm = 1'b0;
			end
		end

		// ****************************************
		// Bridge sequencing
		// ****************************************
		unique case (q.st)
			modbus_bridge_pkg::ST_IDLE: begin
				if (slave) begin
					if (en && rx_v) begin
						start_rx = 1'b1;
						acc = (rx_b == q.id_s2);
					end
				end else begin
					unique case (mode)
						modbus_bridge_pkg::DISP_CYCLIC: go = 1'b1;
						modbus_bridge_pkg::DISP_CHANGE: go = q.req_seen;
						default: go = (q.obuf[0] != q.last_trig);
					endcase
					if (en && go) begin
						n_lim = q.fblen - hdr;
						d.n = len_en ? q.obuf[lenpos] : frame_len(q.obuf[hdr + 8'h01],
							q.obuf[hdr + modbus_bridge_pkg::REQ_BC_POS], 1'b0);
						if (d.n > n_lim) d.n = n_lim;
						d.j = '0;
						d.crc = modbus_bridge_pkg::CRC_INIT;
						d.req_seen = 1'b0;
						d.last_trig = q.obuf[0];
						d.led = q.obuf[hdr];
						d.st = modbus_bridge_pkg::ST_TX;
					end
				end
			end
			modbus_bridge_pkg::ST_TX: begin
				if (!q.tx_busy) begin
					if (q.j < q.n + modbus_bridge_pkg::CRC_BYTES) begin
						if (q.j < q.n) begin
							tx_byte = !slave ? q.obuf[hdr + q.j] :
								(q.j == '0) ? q.id_s2 : q.obuf[hdr + q.j - 8'h01];
							d.crc = crc_step(q.crc, tx_byte);
						end else begin
							tx_byte = (q.j == q.n) ? q.crc[7:0] : q.crc[15:8];
						end
						d.tx_sh = {1'b1, (par == modbus_bridge_pkg::PAR_NONE) ? 1'b1 :
							(par == modbus_bridge_pkg::PAR_EVEN) ? ^tx_byte : ~^tx_byte,
							tx_byte, 1'b0};
						d.txd = 1'b0;
						d.tx_busy = 1'b1;
						d.tx_bits = 4'(modbus_bridge_pkg::CHAR_BITS - 1);
						d.tx_tmr = q.div - 16'h0001;
						d.j = q.j + 8'h01;
					end else begin
						d.tmr = '0;
						d.st = slave ? modbus_bridge_pkg::ST_IDLE : modbus_bridge_pkg::ST_WAIT;
					end
				end
			end
			modbus_bridge_pkg::ST_WAIT: begin
				d.tmr = q.tmr + 32'h0000_0001;
				if (rx_v) begin
					start_rx = 1'b1;
					acc = 1'b1;
				end else if (q.tmr >= q.resp) begin
					d.tmo = 1'b1;
					d.st = modbus_bridge_pkg::ST_IDLE;
				end
			end
			modbus_bridge_pkg::ST_RX: begin
				if (rx_v) begin
					d.crc = crc_step(q.crc, rx_b);
					d.p0 = rx_b;
					d.p1 = q.p0;
					if (q.cnt != 8'hff) d.cnt = q.cnt + 8'h01;
					// Two-byte lag keeps the CRC out of the image
					if (q.accept && q.cnt >= modbus_bridge_pkg::CRC_BYTES) begin
						k = q.cnt - modbus_bridge_pkg::CRC_BYTES;
						pos = hdr + k - {7'h00, slave};
						if (!(slave && k == '0)) begin
							if (pos < q.fblen) d.ibuf[pos] = q.p1;
							else d.ovf = 1'b1;
						end
					end
				end else if (frame_end) begin
					d.st = modbus_bridge_pkg::ST_IDLE;
					if (q.accept && q.crc == '0 && q.cnt >= modbus_bridge_pkg::MIN_FRAME) begin
						if (len_en) d.ibuf[lenpos] = q.cnt - modbus_bridge_pkg::CRC_BYTES -
							{7'h00, slave};
						if (trig_en) d.ibuf[0] = q.ibuf[0] + 8'h01;
						d.fb_upd = 1'b1;
						d.tmr = '0;
						// A master keeps a trigger or request that came during the reply
						if (slave) begin
							d.req_seen = 1'b0;
							d.last_trig = q.obuf[0];
							d.st = modbus_bridge_pkg::ST_FB_WAIT;
						end
					end else if (q.accept) begin
						d.crcerr = 1'b1;
					end
				end
			end
			modbus_bridge_pkg::ST_FB_WAIT: begin
				d.tmr = q.tmr + 32'h0000_0001;
				if (q.req_seen || (trig_en && q.obuf[0] != q.last_trig)) begin
					n_lim = q.fblen - hdr + 8'h01;
					d.n = len_en ? q.obuf[lenpos] + 8'h01 :
						frame_len(q.obuf[hdr], q.obuf[hdr + 8'h01], 1'b1);
					if (d.n > n_lim) d.n = n_lim;
					d.j = '0;
					d.crc = modbus_bridge_pkg::CRC_INIT;
					d.req_seen = 1'b0;
					d.last_trig = q.obuf[0];
					d.led = q.id_s2;
					d.st = modbus_bridge_pkg::ST_TX;
				end else if (q.tmr >= q.resp) begin
					d.tmo = 1'b1;
					d.st = modbus_bridge_pkg::ST_IDLE;
				end
			end
		endcase

		if (start_rx) begin
			d.st = modbus_bridge_pkg::ST_RX;
			d.cnt = 8'h01;
			d.crc = crc_step(modbus_bridge_pkg::CRC_INIT, rx_b);
			d.p0 = rx_b;
			d.accept = acc;
			if (acc) begin
				for (int i = 0; i < BUF_BYTES; i++) begin
					if (!(trig_en && i == 0)) d.ibuf[i] = '0;
				end
			end
		end
		if (!en) d.st = modbus_bridge_pkg::ST_IDLE;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			q <= ST_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign txd = q.txd;
	assign fb_rd_data = q.fb_rd;
	assign fb_update = q.fb_upd;
	assign led_id = q.led;
	assign timeout_err = q.tmo;
	assign rx_overflow = q.ovf;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n || !ce);

	cyclic_restart_a: assert property (
		(q.st == modbus_bridge_pkg::ST_IDLE && q.ctrl[0] && !q.ctrl[1] && q.ctrl[3:2] == 2'h0)
		|=> q.st == modbus_bridge_pkg::ST_TX) else $error("cyclic mode did not resend");
	change_hold_a: assert property (
		(q.st == modbus_bridge_pkg::ST_IDLE && !q.ctrl[1] && q.ctrl[3:2] == 2'h1 && !q.req_seen)
		|=> q.st == modbus_bridge_pkg::ST_IDLE) else $error("send without fieldbus request");
	trig_gate_a: assert property (
		(q.st == modbus_bridge_pkg::ST_IDLE && !q.ctrl[1] && q.ctrl[3:2] == 2'h2
		&& q.obuf[0] == q.last_trig) |=> q.st == modbus_bridge_pkg::ST_IDLE)
		else $error("send without trigger change");
	crc_low_a: assert property (
		(q.st == modbus_bridge_pkg::ST_TX && !q.tx_busy && q.j == q.n)
		|=> q.tx_busy && q.tx_sh[8:1] == $past(q.crc[7:0])) else $error("crc low byte wrong");
	resp_timeout_a: assert property (
		(q.st == modbus_bridge_pkg::ST_WAIT && q.ctrl[0] && q.tmr >= q.resp && !rx_v)
		|=> q.tmo && q.st == modbus_bridge_pkg::ST_IDLE) else $error("reply timeout missed");
	fb_timeout_a: assert property (
		(q.st == modbus_bridge_pkg::ST_FB_WAIT && q.ctrl[0] && q.tmr >= q.resp && !q.req_seen
		&& !(q.ctrl[4] && q.obuf[0] != q.last_trig)) |=> q.tmo) else $error("answer timeout missed");
	trig_count_a: assert property (
		(q.fb_upd && q.ctrl[4]) |-> q.ibuf[0] == 8'($past(q.ibuf[0]) + 8'h01))
		else $error("trigger byte not incremented");
	len_byte_a: assert property (
		(q.fb_upd && q.ctrl[5]) |-> q.ibuf[q.ctrl[4]] == 8'($past(q.cnt) - 8'h02 - q.ctrl[1]))
		else $error("length byte wrong");
	id_filter_a: assert property (
		(q.st == modbus_bridge_pkg::ST_IDLE && q.ctrl[0] && q.ctrl[1] && rx_v && rx_b != q.id_s2)
		##1 (q.st == modbus_bridge_pkg::ST_RX)[*1] |-> !q.accept) else $error("foreign address taken");
	led_show_a: assert property (
		(q.st == modbus_bridge_pkg::ST_TX && $past(q.st) == modbus_bridge_pkg::ST_FB_WAIT)
		|-> q.led == $past(q.id_s2)) else $error("indicator not station address");

	master_cycle_c: cover property (q.fb_upd && !q.ctrl[1]);
	slave_answer_c: cover property (q.st == modbus_bridge_pkg::ST_FB_WAIT ##1
		q.st == modbus_bridge_pkg::ST_TX);
	timeout_c: cover property ($rose(q.tmo));
endmodule

`default_nettype wire

// ---- tb/modbus_rtu_fieldbus_bridge_tb.sv ----
// Self-checking bench for the Modbus-RTU fieldbus bridge.
// Assumes the package, the bridge and the station model are compiled first.
`default_nettype none

module modbus_rtu_fieldbus_bridge_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT = 16;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic fb_wr_en = 1'b0;
	logic fb_req = 1'b0;
	logic [7:0] fb_addr = 8'h00;
	logic [7:0] fb_wr_data = 8'h00;
	logic [31:0] prdata;
	logic pready, pslverr, txd, rxd, fb_update, timeout_err, rx_overflow, seen, e;
	logic [7:0] fb_rd_data, led_id;
	logic [7:0] f[$];
	logic [31:0] r;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;

	always #20 clock = ~clock;

	modbus_rtu_fieldbus_bridge #(.BUF_BYTES(32), .RESP_DEF(2000)) DUT (
		.clock(clock), .arst_n(arst_n), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .station_sw(8'h22),
		.fb_wr_en(fb_wr_en), .fb_addr(fb_addr), .fb_wr_data(fb_wr_data), .fb_req(fb_req),
		.fb_rd_data(fb_rd_data), .fb_update(fb_update), .led_id(led_id),
		.timeout_err(timeout_err), .rx_overflow(rx_overflow)
	);

	rtu_station #(.BIT(BIT)) u_station (.clock(clock), .txd(txd), .rxd(rxd));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, r);
	endtask

	task automatic fbw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		fb_wr_en <= 1'b1;
		fb_addr <= a;
		fb_wr_data <= d;
		@(posedge clock);
		fb_wr_en <= 1'b0;
	endtask

	task automatic fb_pulse();
		@(posedge clock);
		fb_req <= 1'b1;
		@(posedge clock);
		fb_req <= 1'b0;
	endtask

	task automatic fbchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		fb_addr <= a;
		repeat (2) @(posedge clock);
		chk("fieldbus image byte", {24'h0, exp}, {24'h0, fb_rd_data});
	endtask

	task automatic wait_hi(ref logic s, input int lim);
		seen = 1'b0;
		for (int n = 0; n < lim && !seen; n++) begin
			@(posedge clock);
			seen = (s === 1'b1);
		end
	endtask

	task automatic wait_rx(input int cnt);
		for (int n = 0; n < 4000 && u_station.rx_q.size() < cnt; n++) begin
			@(posedge clock);
		end
		repeat (4 * BIT) @(posedge clock);
	endtask

	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[k]) begin
			c = c ^ {8'h00, q[k]};
			for (int j = 0; j < 8; j++) begin
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
			end
		end
		return c;
	endfunction

	task automatic tx_frame(input logic [7:0] q[$]);
		logic [15:0] c;
		c = crc16(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		u_station.send(q);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		chk("txd idle", 32'h0000_0001, {31'h0, txd});
		rdchk("ctrl reset", 8'h00, 32'h0000_0000);
		rdchk("baud reset", 8'h04, 32'h0000_0a2c);
		rdchk("resp reset", 8'h08, 32'h0000_07d0);
		rdchk("fblen reset", 8'h0c, 32'h0000_0020);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0, e});
		apb(1'b1, 8'h04, BIT);
		rdchk("baud written", 8'h04, BIT);
	endtask

	task automatic t_master_ok();
		apb(1'b1, 8'h00, 32'h0000_0019);
		f = '{8'h11, 8'h03, 8'h00, 8'h6b, 8'h00, 8'h03};
		foreach (f[k]) fbw(k + 1, f[k]);
		repeat (300) @(posedge clock);
		chk("no send without trigger", 0, u_station.rx_q.size());
		fbw(8'h00, 8'h01);
		wait_rx(8);
		r = crc16(f);
		f.push_back(r[7:0]);
		f.push_back(r[15:8]);
		chk("request length", 8, u_station.rx_q.size());
		foreach (f[k]) chk("request byte", f[k], u_station.rx_q[k]);
		u_station.rx_q.delete();
		tx_frame('{8'h11, 8'h03, 8'h02, 8'h12, 8'h34});
		wait_hi(fb_update, 1500);
		chk("reply delivered", 1, seen);
		fbchk(8'h00, 8'h01);
		f = '{8'h11, 8'h03, 8'h02, 8'h12, 8'h34, 8'h00};
		foreach (f[k]) fbchk(k + 1, f[k]);
	endtask

	task automatic t_master_err();
		fbw(8'h00, 8'h02);
		wait_rx(8);
		u_station.rx_q.delete();
		apb(1'b1, 8'h0c, 32'h0000_0004);
		tx_frame('{8'h11, 8'h03, 8'h02, 8'h12, 8'h34});
		wait_hi(rx_overflow, 1500);
		chk("overflow flag", 1, seen);
		apb(1'b1, 8'h0c, 32'h0000_0020);
		fbw(8'h00, 8'h03);
		wait_rx(8);
		chk("next request", 8, u_station.rx_q.size());
		wait_hi(timeout_err, 3000);
		chk("timeout flag", 1, seen);
		rdchk("status flags", 8'h10, 32'h0000_1103);
		apb(1'b1, 8'h10, 32'h0000_0003);
		@(posedge clock);
		chk("timeout cleared", 0, timeout_err);
	endtask

	task automatic t_master_len();
		u_station.rx_q.delete();
		apb(1'b1, 8'h00, 32'h0000_0025);
		f = '{8'h11, 8'h03, 8'h00, 8'h6b, 8'h00, 8'h03};
		fbw(8'h00, 8'h06);
		foreach (f[k]) fbw(k + 1, f[k]);
		fbw(8'h07, 8'h55);
		repeat (300) @(posedge clock);
		chk("no send without request", 0, u_station.rx_q.size());
		fb_pulse();
		wait_rx(8);
		chk("length byte request", 8, u_station.rx_q.size());
		foreach (f[k]) chk("length byte data", f[k], u_station.rx_q[k]);
		u_station.rx_q.delete();
		tx_frame('{8'h11, 8'h03, 8'h02, 8'h12, 8'h34});
		wait_hi(fb_update, 1500);
		chk("change reply", 1, seen);
		fbchk(8'h00, 8'h05);
		apb(1'b1, 8'h00, 32'h0000_0021);
		wait_rx(8);
		chk("cyclic request", 8, u_station.rx_q.size());
		apb(1'b1, 8'h00, 32'h0000_0000);
	endtask

	task automatic t_slave();
		apb(1'b1, 8'h00, 32'h0000_0003);
		u_station.rx_q.delete();
		tx_frame('{8'h33, 8'h06, 8'h00, 8'h01, 8'h00, 8'h05});
		wait_hi(fb_update, 1500);
		chk("foreign address ignored", 0, seen);
		f = '{8'h06, 8'h00, 8'h01, 8'h00, 8'h05};
		tx_frame('{8'h22, 8'h06, 8'h00, 8'h01, 8'h00, 8'h05});
		wait_hi(fb_update, 1500);
		chk("own address taken", 1, seen);
		foreach (f[k]) fbchk(k, f[k]);
		fbchk(8'h05, 8'h00);
		foreach (f[k]) fbw(k, f[k]);
		fb_pulse();
		wait_rx(8);
		chk("answer length", 8, u_station.rx_q.size());
		chk("answer address", 8'h22, u_station.rx_q[0]);
		chk("answer crc", 0, crc16(u_station.rx_q));
		chk("station lamps", 8'h22, led_id);
	endtask

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_errors++;
			report_and_stop();
		end
	end

	initial begin
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		t_regs();
		t_master_ok();
		t_master_err();
		t_master_len();
		t_slave();
		report_and_stop();
	end
endmodule

`default_nettype wire

// ---- tb/rtu_station.sv ----
// Behavioural Modbus-RTU station on the serial side of the bridge.
// Assumes the bench clock and a bit time given in clock cycles.
`default_nettype none

module rtu_station #(
	parameter int BIT = 16
) (
	input wire logic clock,
	input wire logic txd,
	output var logic rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rx_q[$];
	logic [7:0] b;
	logic [10:0] w;

	initial rxd = 1'b1;

	// ****************************************
	// Capture of bridge output, LSB first
	// ****************************************
	always begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clock);
			b[i] = txd;
		end
		rx_q.push_back(b);
		repeat (BIT) @(posedge clock);
	end

	// Start, 8 data, two stop bits; line left high after it
	task automatic send(input logic [7:0] f[$]);
		foreach (f[k]) begin
			w = {2'b11, f[k], 1'b0};
			for (int j = 0; j < 11; j++) begin
				rxd <= w[j];
				repeat (BIT) @(posedge clock);
			end
		end
		rxd <= 1'b1;
	endtask
endmodule

`default_nettype wire
